// File: hw/fchp_pkg.sv
// Constants for the host-side controller of a removable flash card port.
// Assumes one 200 MHz clock; all times converted to whole clock cycles.
package fchp_pkg;

  // Clock period
  localparam int CLK_PERIOD_NS = 5;

  // Cycle timing, least times in ns
  localparam int T_ADDR_SETUP_NS = 30;
  localparam int T_WRITE_PULSE_NS = 150;
  localparam int T_RECOVERY_NS = 30;
  localparam int T_RESET_PULSE_NS = 10000;

  // Least times rounded up to cycles
  localparam int ADDR_SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int CNT_W = 12;

  // Configuration option register in attribute space, soft reset bit
  localparam logic [ADDR_W-1:0] CFG_OPT_ADDR = 11'h200;
  localparam int CFG_SRESET_BIT = 7;
  localparam logic [DATA_W-1:0] CFG_SRESET_SET = 16'h0080;
  localparam logic [DATA_W-1:0] CFG_SRESET_CLR = 16'h0000;

  // Soft reset sequence steps
  localparam logic [1:0] SR_NONE = 2'h0;
  localparam logic [1:0] SR_SET = 2'h1;
  localparam logic [1:0] SR_CLR = 2'h2;

  // Controller states
  typedef enum logic [2:0] {
    FCHP_RESET = 3'b000,
    FCHP_RDYWAIT = 3'b001,
    FCHP_IDLE = 3'b010,
    FCHP_SETUP = 3'b011,
    FCHP_STROBE = 3'b100,
    FCHP_RECOV = 3'b101
  } fchp_state_t;

endpackage

// File: hw/fchp_dstrobe_cap.sv
// Dual-edge capture of card-driven data-out strobe for Ultra DMA reads.
// Assumes strobe and data pins are synchronous to i_mclk.
`timescale 1ns/1ps
module fchp_dstrobe_cap
  import fchp_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Capture enable and pins
  input wire logic i_en,
  input wire logic i_strobe,
  input wire logic [DATA_W-1:0] i_data,
  // Captured word
  output logic o_valid,
  output logic [DATA_W-1:0] o_data
);

  logic stb_prev_reg;
  logic valid_reg;
  logic [DATA_W-1:0] data_reg;
  wire edge_seen;

  // Either transition latches a word; no edges means a paused burst
  assign edge_seen = i_en & (i_strobe ^ stb_prev_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Edge history and capture
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      stb_prev_reg <= 1'b0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      stb_prev_reg <= i_strobe;
      valid_reg <= edge_seen;
      if (edge_seen) begin
        data_reg <= i_data;
      end
    end
  end

  assign o_valid = valid_reg;
  assign o_data = data_reg;

endmodule

// File: hw/fchp_host.sv
// Host controller for a flash card parallel port: memory, I/O and IDE modes.
// Assumes all card pins are synchronous to i_mclk; data bus is split in/out/oe.
//
// Summary of operation
// - Space select high for common memory, low for attribute memory.
// - Space select held low throughout I/O cycles.
// - In IDE mode acknowledge DMA only in answer to card DMA request.
// - Without DMA enabled, DMA acknowledge is held high.
// - Card's wait low stretches the cycle; host completes only after release.
// - Host asserts data-in ready while an Ultra DMA data-in is active and i_rx_ready is high.
// - Host latches data on both edges of the card's data strobe.
// - In memory mode write strobe writes memory data and configuration.
// - IDE mode selected by grounding the mode-select input.
`timescale 1ns/1ps
module fchp_host
  import fchp_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_CYC
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Mode and control
  input wire logic i_ide_mode,
  input wire logic i_dma_en,
  input wire logic i_udma_in,
  input wire logic i_udma_out,
  input wire logic i_rx_ready,
  input wire logic i_hw_reset,
  input wire logic i_soft_reset,
  // Access request port
  input wire logic i_req,
  input wire logic i_io,
  input wire logic i_attr,
  input wire logic i_wr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_req_ready,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // Ultra DMA read data
  output logic o_udma_valid,
  output logic [DATA_W-1:0] o_udma_data,
  // Card control pins
  output logic o_card_reset,
  output logic o_ata_sel_b,
  output logic o_ce_b,
  output logic o_reg_b,
  output logic o_oe_b,
  output logic o_we_b,
  output logic o_iord_b,
  output logic o_iowr_b,
  output logic o_dmack_b,
  output logic o_ddmardy_b,
  output logic [ADDR_W-1:0] o_addr,
  input wire logic i_ready,
  input wire logic i_wait_b,
  input wire logic i_dmarq,
  input wire logic i_dstrobe,
  // Card data bus
  input wire logic [DATA_W-1:0] i_d,
  output logic [DATA_W-1:0] o_d,
  output logic o_d_oe_b
);

  // Cycle counts trimmed to counter width
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  fchp_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] sr_reg, sr_next;
  logic io_reg, attr_reg, wr_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  logic done_reg, done_next;
  logic dmack_reg, ddmardy_reg;
  logic ce_reg, strobe_reg;

  wire cnt_zero;
  wire rst_active;
  wire start_user;
  wire start_soft;
  wire seq_busy;
  wire cycle_held;

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  assign cnt_zero = (cnt_reg == '0);
  assign rst_active = (state_reg == FCHP_RESET);
  assign seq_busy = (sr_reg != SR_NONE);
  assign start_user = (state_reg == FCHP_IDLE) & i_req & ~seq_busy & ~i_soft_reset;
  assign start_soft = (state_reg == FCHP_IDLE) & (i_soft_reset | seq_busy);
  assign cycle_held = ~i_wait_b;

  //////////////////////////////////////////////////////////////////////////////
  // State and counter next values
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - CNT_W'(1);
    sr_next = sr_reg;
    done_next = 1'b0;
    case (state_reg)
      FCHP_RESET: begin
        if (cnt_zero) begin
          state_next = FCHP_RDYWAIT;
        end
      end
      FCHP_RDYWAIT: begin
        if (i_ready) begin
          state_next = FCHP_IDLE;
        end
      end
      FCHP_IDLE: begin
        if (i_hw_reset) begin
          state_next = FCHP_RESET;
          cnt_next = cyc(RESET_CYCLES);
        end else if (start_soft) begin
          state_next = FCHP_SETUP;
          cnt_next = cyc(ADDR_SETUP_CYC);
          sr_next = seq_busy ? sr_reg : SR_SET;
        end else if (start_user) begin
          state_next = FCHP_SETUP;
          cnt_next = cyc(ADDR_SETUP_CYC);
        end
      end
      FCHP_SETUP: begin
        if (cnt_zero) begin
          state_next = FCHP_STROBE;
          cnt_next = cyc(STROBE_CYC);
        end
      end
      FCHP_STROBE: begin
        if (cnt_zero && !cycle_held) begin
          state_next = FCHP_RECOV;
          cnt_next = cyc(RECOVERY_CYC);
        end
      end
      FCHP_RECOV: begin
        if (cnt_zero) begin
          state_next = FCHP_IDLE;
          if (sr_reg == SR_SET) begin
            sr_next = SR_CLR;
          end else if (sr_reg == SR_CLR) begin
            sr_next = SR_NONE;
            state_next = FCHP_RDYWAIT;
          end else begin
            done_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = FCHP_RESET;
        cnt_next = cyc(RESET_CYCLES);
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_reg <= FCHP_RESET;
      cnt_reg <= cyc(RESET_CYCLES);
      sr_reg <= SR_NONE;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      done_reg <= done_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request latch; soft reset writes go to attribute configuration space
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      io_reg <= 1'b0;
      attr_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (start_soft && !i_hw_reset) begin
      io_reg <= 1'b0;
      attr_reg <= 1'b1;
      wr_reg <= 1'b1;
      addr_reg <= CFG_OPT_ADDR;
      wdata_reg <= (seq_busy && sr_reg == SR_CLR) ? CFG_SRESET_CLR : CFG_SRESET_SET;
    end else if (start_user && !i_hw_reset) begin
      io_reg <= i_io;
      attr_reg <= i_attr;
      wr_reg <= i_wr;
      addr_reg <= i_addr;
      wdata_reg <= i_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin timing: enable over the whole cycle, strobe only in its phase
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ce_reg <= 1'b0;
      strobe_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ce_reg <= (state_next == FCHP_SETUP) | (state_next == FCHP_STROBE) |
                (state_next == FCHP_RECOV);
      strobe_reg <= (state_next == FCHP_STROBE);
      if (state_reg == FCHP_STROBE && cnt_zero && !cycle_held && !wr_reg) begin
        rdata_reg <= i_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DMA handshake registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      dmack_reg <= 1'b0;
      ddmardy_reg <= 1'b0;
    end else begin
      dmack_reg <= i_ide_mode & i_dma_en & i_dmarq & ~rst_active;
      ddmardy_reg <= i_ide_mode & i_udma_in & i_rx_ready;
    end
  end

  // Ultra DMA data-out capture on both strobe edges
  fchp_dstrobe_cap u_dstrobe_cap (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_en(i_ide_mode & i_udma_out & dmack_reg),
    .i_strobe(i_dstrobe),
    .i_data(i_d),
    .o_valid(o_udma_valid),
    .o_data(o_udma_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive
  assign o_card_reset = i_ide_mode ? ~rst_active : rst_active;
  assign o_ata_sel_b = ~i_ide_mode;
  assign o_ce_b = ~ce_reg;
  assign o_reg_b = ~(ce_reg & (io_reg | attr_reg));
  assign o_oe_b = ~(strobe_reg & ~io_reg & ~wr_reg);
  assign o_we_b = ~(strobe_reg & ~io_reg & wr_reg);
  assign o_iord_b = ~(strobe_reg & io_reg & ~wr_reg);
  assign o_iowr_b = ~(strobe_reg & io_reg & wr_reg);
  assign o_dmack_b = ~dmack_reg;
  assign o_ddmardy_b = ~ddmardy_reg;
  assign o_addr = addr_reg;
  assign o_d = wdata_reg;
  assign o_d_oe_b = ~(ce_reg & wr_reg);
  assign o_req_ready = (state_reg == FCHP_IDLE) & ~seq_busy & ~i_soft_reset & ~i_hw_reset;
  assign o_done = done_reg;
  assign o_rdata = rdata_reg;

endmodule

// File: tb/fchp_host_sva.sv
// Port checker for the host controller.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module fchp_host_sva
  import fchp_pkg::*;
(
  // Clock, reset, user side
  input wire logic i_mclk, i_rst_b, i_ide_mode, i_dma_en, i_udma_out, i_req, i_io, i_attr, i_wr,
  input wire logic o_req_ready, o_udma_valid,
  input wire logic [DATA_W-1:0] o_udma_data, i_d,
  // Card pins
  input wire logic o_card_reset, o_ata_sel_b, o_reg_b, o_oe_b, o_we_b, o_iord_b, o_iowr_b,
  input wire logic o_dmack_b, i_wait_b, i_dmarq, i_dstrobe, o_ce_b, o_d_oe_b
);
  ////////////////////////////////////////
  // Request taken, any strobe low
  wire take = i_req && o_req_ready;
  wire strb = !(o_we_b && o_oe_b && o_iord_b && o_iowr_b);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sel_map_a: assert property (o_ata_sel_b == !i_ide_mode)
    else $error("mode select wrong");
  space_sel_a: assert property (take |=> o_reg_b == !($past(i_attr) || $past(i_io)))
    else $error("space select wrong");
  io_space_a: assert property (!(o_iord_b && o_iowr_b) |-> !o_reg_b)
    else $error("space select high in io cycle");
  mem_we_a: assert property (take && i_wr && !i_io |-> ##7 !o_we_b && o_iowr_b)
    else $error("memory write strobe wrong");
  io_wr_a: assert property (take && i_wr && i_io |-> ##7 !o_iowr_b && o_we_b)
    else $error("io write strobe wrong");
  cyc_pins_a: assert property (strb |-> !o_ce_b && (o_d_oe_b == (o_we_b && o_iowr_b)))
    else $error("enable or data drive wrong in strobe");
  wait_hold_a: assert property (strb && !i_wait_b |=> strb)
    else $error("strobe ended during wait");
  dmack_a: assert property (1 |=> o_dmack_b == !$past(i_ide_mode && i_dma_en && i_dmarq))
    else $error("dma acknowledge wrong");
  udma_cap_a: assert property ($changed(i_dstrobe) && i_ide_mode && i_udma_out && !o_dmack_b
    |=> o_udma_valid && o_udma_data == $past(i_d))
    else $error("strobe word not captured");
  udma_pause_a: assert property ($stable(i_dstrobe) |=> !o_udma_valid)
    else $error("word without strobe edge");
  rst_pin_a: assert property ($rose(i_rst_b) |-> o_card_reset == !i_ide_mode)
    else $error("card reset polarity wrong");
  busy_hold_a: assert property (o_card_reset == !i_ide_mode |-> !o_req_ready)
    else $error("request open during card reset");
  // Main scenarios
  cover property (take && i_io);
  cover property (strb && !i_wait_b);
  cover property (o_udma_valid);
endmodule

// File: tb/fchp_card_model.sv
// Behavioural card: ready, wait and read data on the far side of the host.
// Assumes the host pins are synchronous to i_mclk.
`timescale 1ns/1ps
module fchp_card_model
  import fchp_pkg::*;
(
  // Host pins
  input wire logic i_mclk, i_card_reset, i_ata_sel_b, i_reg_b, i_oe_b, i_we_b, i_iord_b, i_iowr_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_d,
  input wire logic [7:0] i_wait_len,
  // Card answers
  output logic o_ready, o_wait_b,
  output logic [DATA_W-1:0] o_d
);
  ////////////////////////////////////////
  logic seen_reg = 1'b0;
  logic we_q_reg = 1'b1;
  logic strb_q_reg = 1'b0;
  logic [3:0] busy_reg = 4'h8;
  logic [7:0] wcnt_reg = 8'h00;
  logic [DATA_W-1:0] last_reg = 16'h0000;
  // Pin polarity by mode; the DMA acknowledge pin is never looked at
  wire pin_on = i_ata_sel_b ? i_card_reset : !i_card_reset;
  wire strb = !(i_oe_b && i_we_b && i_iord_b && i_iowr_b);
  wire rd = !(i_oe_b && i_iord_b);
  wire cfg_wr = !we_q_reg && i_we_b && !i_reg_b && i_addr == CFG_OPT_ADDR && i_d[CFG_SRESET_BIT];
  // Busy after reset, wait count per strobe
  always_ff @(posedge i_mclk) begin
    if (!pin_on) seen_reg <= 1'b1;
    if ((pin_on && seen_reg) || cfg_wr) busy_reg <= 4'h8;
    else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
    if (strb && !strb_q_reg) wcnt_reg <= i_wait_len;
    else if (wcnt_reg != 8'h00) wcnt_reg <= wcnt_reg - 8'h01;
    if (rd) last_reg <= o_d;
    we_q_reg <= i_we_b;
    strb_q_reg <= strb;
  end
  assign o_ready = busy_reg == 4'h0;
  assign o_wait_b = !(strb && wcnt_reg != 8'h00);
  // Released bus shows the inverse of the last word
  assign o_d = rd ? ({5'h00, i_addr} ^ 16'ha5a5) : ~last_reg;
endmodule

// File: tb/test_fchp_host.sv
// Testbench for the host controller against the card model.
// Assumes a short card reset count of 4 cycles.
`timescale 1ns/1ps
module test_fchp_host
  import fchp_pkg::*;
;
  ////////////////////////////////////////
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_ide_mode = 1'b0, i_dma_en = 1'b0, i_udma_in = 1'b0;
  logic i_udma_out = 1'b0, i_rx_ready = 1'b0, i_hw_reset = 1'b0, i_soft_reset = 1'b0;
  logic i_req = 1'b0, i_io = 1'b0, i_attr = 1'b0, i_wr = 1'b0, i_dmarq = 1'b0, i_dstrobe = 1'b0;
  logic [ADDR_W-1:0] i_addr = 11'h000, o_addr;
  logic [DATA_W-1:0] i_wdata = 16'h0000, udma_d = 16'h0000, o_rdata, o_udma_data, o_d, card_d;
  logic [7:0] wait_len = 8'h00;
  logic o_req_ready, o_done, o_udma_valid, o_card_reset, o_ata_sel_b, o_reg_b, o_oe_b, o_we_b;
  logic o_iord_b, o_iowr_b, o_dmack_b, o_ddmardy_b, i_ready, i_wait_b;
  int n_fail = 0, checked = 0, cyc = 0;
  wire [DATA_W-1:0] i_d = i_udma_out ? udma_d : card_d;
  fchp_host #(.RESET_CYCLES(4)) u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_ide_mode(i_ide_mode), .i_dma_en(i_dma_en), .i_udma_in(i_udma_in), .i_udma_out(i_udma_out),
    .i_rx_ready(i_rx_ready), .i_hw_reset(i_hw_reset), .i_soft_reset(i_soft_reset), .i_req(i_req),
    .i_io(i_io), .i_attr(i_attr), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata), .o_udma_valid(o_udma_valid),
    .o_udma_data(o_udma_data), .o_card_reset(o_card_reset), .o_ata_sel_b(o_ata_sel_b),
    .o_ce_b(), .o_reg_b(o_reg_b), .o_oe_b(o_oe_b), .o_we_b(o_we_b), .o_iord_b(o_iord_b),
    .o_iowr_b(o_iowr_b), .o_dmack_b(o_dmack_b), .o_ddmardy_b(o_ddmardy_b), .o_addr(o_addr),
    .i_ready(i_ready), .i_wait_b(i_wait_b), .i_dmarq(i_dmarq), .i_dstrobe(i_dstrobe), .i_d(i_d),
    .o_d(o_d), .o_d_oe_b());
  fchp_card_model u_card (.i_mclk(i_mclk), .i_card_reset(o_card_reset),
    .i_ata_sel_b(o_ata_sel_b), .i_reg_b(o_reg_b), .i_oe_b(o_oe_b), .i_we_b(o_we_b),
    .i_iord_b(o_iord_b), .i_iowr_b(o_iowr_b), .i_addr(o_addr), .i_d(o_d),
    .i_wait_len(wait_len), .o_ready(i_ready), .o_wait_b(i_wait_b), .o_d(card_d));
  // Clock and hang limit
  initial forever #2.5 i_mclk = !i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input logic [DATA_W-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One access, cycles from take to done
  task acc(input logic io, at, wr, input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] lat);
    while (o_req_ready !== 1'b1) @(negedge i_mclk);
    {i_io, i_attr, i_wr, i_addr, i_wdata} = {io, at, wr, a, {5'h00, a} ^ 16'h5a5a};
    i_req = 1'b1;
    @(negedge i_mclk);
    i_req = 1'b0;
    lat = 16'h0000;
    while (o_done !== 1'b1) begin
      @(negedge i_mclk);
      lat++;
    end
  endtask
  task s_access;
    logic [DATA_W-1:0] lat;
    for (int k = 0; k < 4; k++) begin
      acc(k[1], !k[1] && k[0], !k[0], 11'h040 + 11'(k), lat);
      chk(lat, 16'(ADDR_SETUP_CYC + STROBE_CYC + RECOVERY_CYC));
      chk(16'(o_addr), 16'(11'h040 + 11'(k)));
      if (k[0]) chk(o_rdata, {5'h00, 11'h040 + 11'(k)} ^ 16'ha5a5);
      else chk(o_d, {5'h00, 11'h040 + 11'(k)} ^ 16'h5a5a);
    end
  endtask
  task s_wait;
    logic [DATA_W-1:0] lat;
    wait_len = 8'h28;
    for (int m = 0; m < 2; m++) begin
      i_ide_mode = m[0];
      acc(m[0], 1'b0, 1'b0, 11'h011, lat);
      chk(16'(lat > 16'(ADDR_SETUP_CYC + STROBE_CYC + RECOVERY_CYC)), 16'h0001);
    end
    {wait_len, i_ide_mode} = 9'h000;
  endtask
  task s_reset;
    for (int m = 0; m < 2; m++) begin
      i_ide_mode = m[0];
      while (o_req_ready !== 1'b1) @(negedge i_mclk);
      i_hw_reset = 1'b1;
      @(negedge i_mclk);
      i_hw_reset = 1'b0;
      chk(16'(o_card_reset), 16'(!m[0]));
      chk(16'(o_req_ready), 16'h0000);
    end
    i_ide_mode = 1'b0;
  endtask
  task s_soft;
    logic seen;
    seen = 1'b0;
    while (o_req_ready !== 1'b1) @(negedge i_mclk);
    i_soft_reset = 1'b1;
    @(negedge i_mclk);
    i_soft_reset = 1'b0;
    while (o_req_ready !== 1'b1) begin
      if (i_ready === 1'b0) seen = 1'b1;
      @(negedge i_mclk);
    end
    chk(16'(seen), 16'h0001);
  endtask
  task s_dma;
    {i_ide_mode, i_dma_en, i_dmarq, i_udma_in, i_rx_ready} = 5'h1f;
    repeat (2) @(negedge i_mclk);
    chk(16'({o_dmack_b, o_ddmardy_b}), 16'h0000);
    i_udma_out = 1'b1;
    for (int k = 0; k < 4; k++) begin
      udma_d = 16'hc350 + 16'(k);
      i_dstrobe = !i_dstrobe;
      repeat (2) @(negedge i_mclk);
      chk(o_udma_data, 16'hc350 + 16'(k));
    end
    @(negedge i_mclk);
    chk(16'(o_udma_valid), 16'h0000);
    {i_udma_out, i_udma_in, i_dma_en} = 3'h0;
    repeat (2) @(negedge i_mclk);
    chk(16'(o_dmack_b), 16'h0001);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst_b = 1'b1;
    s_access;
    s_wait;
    s_reset;
    s_soft;
    s_dma;
    end_of_test;
  end
endmodule
bind fchp_host fchp_host_sva u_sva (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ide_mode(i_ide_mode),
  .i_dma_en(i_dma_en), .i_udma_out(i_udma_out), .i_req(i_req), .i_io(i_io), .i_attr(i_attr),
  .i_wr(i_wr), .o_req_ready(o_req_ready), .o_udma_valid(o_udma_valid), .i_d(i_d),
  .o_udma_data(o_udma_data), .o_card_reset(o_card_reset), .o_ata_sel_b(o_ata_sel_b),
  .o_reg_b(o_reg_b), .o_oe_b(o_oe_b), .o_we_b(o_we_b), .o_iord_b(o_iord_b),
  .o_iowr_b(o_iowr_b), .o_dmack_b(o_dmack_b), .i_wait_b(i_wait_b), .i_dmarq(i_dmarq),
  .i_dstrobe(i_dstrobe), .o_ce_b(o_ce_b), .o_d_oe_b(o_d_oe_b));
